// ### logic/tlic_top.sv
`timescale 1ns/1ps

// ************************************************************
// two level interrupt controller
// ************************************************************

// Summary of operation
// - block every request, nmi too, after reset
// - first instruction always runs before any interrupt
// - nmi, six request pins, thirty peripheral sources
// - each source has its own vector
// - nmi highest priority, ignores masks and levels
// - per module two levels, arbitrate simultaneous requests
// - three mask levels from mask and user bits
// - trap sets mask, also user bit if user bit enable is 0
// - trap vector chosen by number 0 to 3
// - word accesses force address lsb to zero
// - each pin falling edge or low level
// - nmi edge select: 0 falling, 1 rising
// - user bit enable: 0 mask, 1 user
// - system control loads 0b on reset, standby
// - status flags cleared by zero, one ignored
// - level a bits map pins, watchdog and refresh, and the first three timer channels
// - level a clears to 00 on reset
// - watchdog and refresh requests are peripheral sources
// - take only at instruction or exception end
// - taking saves state, sets mask, jumps vector
module tlic_top (
    input wire logic clk_i, // 20 MHz system clock
    input wire logic srst_i, // sync reset, active high
    input wire logic hw_standby_i, // hardware standby, resets regs
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pwrite_i, // apb direction
    input wire logic [tlic_pkg::ADDR_W-1:0] paddr_i, // apb address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o, // apb read data
    output logic pready_o, // apb ready
    output logic pslverr_o, // apb error, unmapped
    input wire logic nmi_i, // nonmaskable pin
    input wire logic [tlic_pkg::NUM_PINS-1:0] irq_n_i, // request pins
    input wire logic [tlic_pkg::NUM_INT-1:0] int_req_i, // peripherals
    input wire logic imask_i, // cpu mask bit
    input wire logic umask_i, // cpu user or mask bit
    input wire logic boundary_i, // instruction or exception done
    input wire logic trap_i, // trap instruction waiting
    input wire logic [1:0] trap_num_i, // trap vector number
    input wire logic word_acc_i, // word or longword access
    input wire logic [tlic_pkg::CPU_AW-1:0] acc_addr_i, // cpu address
    output logic [tlic_pkg::CPU_AW-1:0] acc_addr_o, // aligned address
    output logic exc_take_o, // exception start pulse
    output logic [7:0] exc_vector_o, // vector number
    output logic [15:0] exc_vec_addr_o, // vector table address
    output logic set_i_o, // set cpu mask bit
    output logic set_um_o, // set cpu user or mask bit
    output logic int_pend_o // acceptable request waiting
);

    localparam int NS = tlic_pkg::NUM_SRC;
    localparam int NP = tlic_pkg::NUM_PINS;

    // ************************************************************
    // declarations
    // ************************************************************
    logic rst;
    logic [7:0] sysctl_r, sense_r, enable_r, prio_a_r, prio_b_r;
    logic [NP-1:0] stat_r, stat_nxt, seen_r, seen_nxt, pin_prev_r;
    logic nmi_prev_r, nmi_pend_r, nmi_pend_nxt, nmi_set;
    tlic_pkg::tlic_state_t state_r, state_nxt;
    logic pready_r, pready_nxt, pslverr_r;
    logic [31:0] prdata_r;
    logic apb_acc, apb_done, wr_en, rd_en;
    logic hit_sys, hit_sen, hit_ena, hit_sta, hit_pra, hit_prb;
    logic map_ok;
    logic [7:0] rd_val;
    logic ube, nes;
    logic [15:0] pab;
    logic [NS-1:0] req, lvl, cand1, cand0;
    logic ok0, ok1, any1, any_mask, int_go;
    logic take_int, take_trap, take_any, run_st;
    logic [tlic_pkg::SRC_W-1:0] win;
    logic [7:0] win_vec, vec_nxt;
    logic [NP-1:0] fall, set_w, hw_clr, sw_clr, pin_taken;
    logic [tlic_pkg::CPU_AW-1:0] addr_nxt;
    logic exc_take_r, set_i_r, set_um_r, int_pend_r;
    logic [7:0] vec_r;
    logic [15:0] vec_addr_r;
    logic [tlic_pkg::CPU_AW-1:0] acc_addr_r;

    // lowest set index wins, so equal levels go to the lower vector
    function automatic logic [tlic_pkg::SRC_W-1:0] first_set(
        input logic [NS-1:0] v);
        logic [tlic_pkg::SRC_W-1:0] idx;
        idx = '0;
        for (int j = NS - 1; j >= 0; j--) begin
            if (v[j]) begin
                idx = tlic_pkg::SRC_W'(j);
            end
        end
        return idx;
    endfunction

    // distinct vector for every source
    function automatic logic [7:0] src_vec(
        input logic [tlic_pkg::SRC_W-1:0] s);
        if (s < tlic_pkg::SRC_W'(NP)) begin
            return tlic_pkg::VEC_PIN + 8'(s);
        end else begin
            return tlic_pkg::VEC_INT + 8'(s) - 8'(NP);
        end
    endfunction

    // hardware standby resets the registers exactly as the pin does
    assign rst = srst_i | hw_standby_i;

    // ************************************************************
    // apb slave: one wait state, pready from a flop
    // ************************************************************
    assign apb_acc = psel_i & penable_i;
    assign apb_done = apb_acc & pready_r;
    assign wr_en = apb_done & pwrite_i;
    assign rd_en = apb_done & ~pwrite_i;
    assign pready_nxt = apb_acc & ~pready_r;

    // address decode against index times four
    assign hit_sys = paddr_i == {tlic_pkg::SYSCTL_IDX, tlic_pkg::WORD_LSBS};
    assign hit_sen = paddr_i == {tlic_pkg::SENSE_IDX, tlic_pkg::WORD_LSBS};
    assign hit_ena = paddr_i == {tlic_pkg::ENABLE_IDX, tlic_pkg::WORD_LSBS};
    assign hit_sta = paddr_i == {tlic_pkg::STATUS_IDX, tlic_pkg::WORD_LSBS};
    assign hit_pra = paddr_i == {tlic_pkg::PRIO_A_IDX, tlic_pkg::WORD_LSBS};
    assign hit_prb = paddr_i == {tlic_pkg::PRIO_B_IDX, tlic_pkg::WORD_LSBS};

    // read selection; reserved status bits read as zero
    always_comb begin
        map_ok = 1'b1;
        rd_val = 8'h00;
        if (hit_sys) begin
            rd_val = sysctl_r;
        end else if (hit_sen) begin
            rd_val = sense_r;
        end else if (hit_ena) begin
            rd_val = enable_r;
        end else if (hit_sta) begin
            rd_val = {{(8 - NP){1'b0}}, stat_r};
        end else if (hit_pra) begin
            rd_val = prio_a_r;
        end else if (hit_prb) begin
            rd_val = prio_b_r;
        end else begin
            map_ok = 1'b0;
        end
    end

    // data is loaded with pready so it is stable when sampled
    always_ff @(posedge clk_i) begin
        if (rst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= pready_nxt;
            if (pready_nxt) begin
                prdata_r <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
                pslverr_r <= ~map_ok;
            end
        end
    end

    // ************************************************************
    // control registers; software standby leaves them alone
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst) begin
            sysctl_r <= tlic_pkg::SYSCTL_RST;
            sense_r <= tlic_pkg::REG_RST;
            enable_r <= tlic_pkg::REG_RST;
            prio_a_r <= tlic_pkg::REG_RST;
            prio_b_r <= tlic_pkg::REG_RST;
        end else if (wr_en) begin
            if (hit_sys) sysctl_r <= pwdata_i[7:0];
            if (hit_sen) sense_r <= pwdata_i[7:0];
            if (hit_ena) enable_r <= pwdata_i[7:0];
            if (hit_pra) prio_a_r <= pwdata_i[7:0];
            if (hit_prb) prio_b_r <= pwdata_i[7:0];
        end
    end

    assign ube = sysctl_r[tlic_pkg::UBE_BIT];
    assign nes = sysctl_r[tlic_pkg::NES_BIT];
    assign pab = {prio_a_r, prio_b_r};

    // ************************************************************
    // request pins: sense, status flags, clear by zero after read
    // ************************************************************
    for (genvar i = 0; i < NP; i++) begin : g_pin
        assign fall[i] = pin_prev_r[i] & ~irq_n_i[i];
        // edge or low level per pin
        assign set_w[i] = sense_r[i] ? fall[i] : ~irq_n_i[i];
        assign pin_taken[i] = take_int & ~nmi_pend_r
            & (win == tlic_pkg::SRC_W'(i));
        // level mode clears on service only once the pin is high
        assign hw_clr[i] = pin_taken[i] & (sense_r[i] | irq_n_i[i]);
        // a one written is ignored, zero clears a flag seen as one
        assign sw_clr[i] = wr_en & hit_sta & ~pwdata_i[i] & seen_r[i];
        // a new request beats a clear in the same cycle
        assign stat_nxt[i] = set_w[i]
            | (stat_r[i] & ~hw_clr[i] & ~sw_clr[i]);
        assign seen_nxt[i] = (seen_r[i] | (rd_en & hit_sta & stat_r[i]))
            & ~sw_clr[i] & stat_nxt[i];
    end

    // pins idle high, so prev starts high to avoid a false edge
    always_ff @(posedge clk_i) begin
        if (rst) begin
            stat_r <= '0;
            seen_r <= '0;
            pin_prev_r <= '1;
        end else begin
            stat_r <= stat_nxt;
            seen_r <= seen_nxt;
            pin_prev_r <= irq_n_i;
        end
    end

    // ************************************************************
    // nonmaskable edge latch
    // ************************************************************
    assign nmi_set = nes ? (~nmi_prev_r & nmi_i)
                         : (nmi_prev_r & ~nmi_i);
    assign nmi_pend_nxt = nmi_set | (nmi_pend_r & ~take_int);

    always_ff @(posedge clk_i) begin
        if (rst) begin
            nmi_prev_r <= 1'b0;
            nmi_pend_r <= 1'b0;
        end else begin
            nmi_prev_r <= nmi_i;
            nmi_pend_r <= nmi_pend_nxt;
        end
    end

    // ************************************************************
    // sources, levels and masking
    // ************************************************************
    for (genvar s = 0; s < NS; s++) begin : g_src
        if (s < NP) begin : g_p
            assign req[s] = stat_r[s] & enable_r[s];
            assign lvl[s] = pab[tlic_pkg::pin_prio_bit(s)];
        end else begin : g_i
            // slots 0 and 1 are watchdog and refresh timer events
            assign req[s] = int_req_i[s - NP];
            assign lvl[s] = pab[tlic_pkg::int_prio_bit(s - NP)];
        end
    end

    // mask bit alone, or mask and user bit as two levels
    assign ok0 = ~imask_i;
    assign ok1 = ube ? ~imask_i : (~imask_i | ~umask_i);
    assign cand1 = req & lvl & {NS{ok1}};
    assign cand0 = req & ~lvl & {NS{ok0}};
    assign any1 = |cand1;
    assign any_mask = any1 | (|cand0);
    // high level first, then lowest index inside the level
    assign win = any1 ? first_set(cand1) : first_set(cand0);
    assign win_vec = src_vec(win);

    // ************************************************************
    // acceptance sequencer
    // ************************************************************
    // nothing, nmi included, is taken until the first instruction
    // boundary after reset, so software can set its stack first
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tlic_pkg::st_block: begin
                if (boundary_i) begin
                    state_nxt = tlic_pkg::st_run;
                end
            end
            tlic_pkg::st_run: begin
                state_nxt = tlic_pkg::st_run;
            end
            default: begin
                state_nxt = tlic_pkg::st_block;
            end
        endcase
    end

    assign run_st = state_r == tlic_pkg::st_run;
    assign int_go = nmi_pend_r | any_mask;
    assign take_int = run_st & boundary_i & int_go;
    // a trap waits behind any interrupt at the same boundary
    assign take_trap = run_st & boundary_i & ~int_go & trap_i;
    assign take_any = take_int | take_trap;
    assign vec_nxt = take_trap ? tlic_pkg::VEC_TRAP + 8'(trap_num_i)
                   : nmi_pend_r ? tlic_pkg::VEC_NMI : win_vec;
    assign addr_nxt = word_acc_i
        ? {acc_addr_i[tlic_pkg::CPU_AW-1:1], 1'b0} : acc_addr_i;

    always_ff @(posedge clk_i) begin
        if (rst) begin
            state_r <= tlic_pkg::st_block;
        end else begin
            state_r <= state_nxt;
        end
    end

    // the cpu pushes pc and condition codes, then fetches the vector
    always_ff @(posedge clk_i) begin
        if (rst) begin
            exc_take_r <= 1'b0;
            vec_r <= 8'h00;
            vec_addr_r <= 16'h0000;
            set_i_r <= 1'b0;
            set_um_r <= 1'b0;
            int_pend_r <= 1'b0;
            acc_addr_r <= '0;
        end else begin
            exc_take_r <= take_any;
            set_i_r <= take_any;
            set_um_r <= take_trap & ~ube;
            int_pend_r <= int_go & run_st;
            acc_addr_r <= addr_nxt;
            if (take_any) begin
                vec_r <= vec_nxt;
                vec_addr_r <= 16'(vec_nxt) << tlic_pkg::VEC_SH;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign exc_take_o = exc_take_r;
    assign exc_vector_o = vec_r;
    assign exc_vec_addr_o = vec_addr_r;
    assign set_i_o = set_i_r;
    assign set_um_o = set_um_r;
    assign int_pend_o = int_pend_r;
    assign acc_addr_o = acc_addr_r;

    // ************************************************************
    // checks
    // ************************************************************
    chk_block_after_reset: assert property (
        @(posedge clk_i) disable iff (rst)
        !run_st |=> !exc_take_o)
        else $error("exception taken before first instruction");

    chk_first_instr_runs: assert property (
        @(posedge clk_i) disable iff (rst)
        (!run_st && !boundary_i) |=> !run_st)
        else $error("left blocked state without a boundary");

    chk_nmi_wins: assert property (
        @(posedge clk_i) disable iff (rst)
        (take_int && nmi_pend_r)
        |=> exc_take_o && exc_vector_o == tlic_pkg::VEC_NMI)
        else $error("pending nmi not taken first");

    chk_take_at_boundary: assert property (
        @(posedge clk_i) disable iff (rst)
        exc_take_o |-> $past(boundary_i))
        else $error("exception started between boundaries");

    chk_trap_mask_bits: assert property (
        @(posedge clk_i) disable iff (rst)
        take_trap |=> set_i_o && (set_um_o == !$past(ube)))
        else $error("trap mask update wrong");

    chk_trap_vector: assert property (
        @(posedge clk_i) disable iff (rst)
        take_trap |=> exc_vector_o
            == tlic_pkg::VEC_TRAP + 8'($past(trap_num_i)))
        else $error("trap vector wrong");

    chk_sysctl_reset: assert property (
        @(posedge clk_i)
        rst |=> sysctl_r == tlic_pkg::SYSCTL_RST)
        else $error("system control reset value wrong");

    chk_prio_reset: assert property (
        @(posedge clk_i)
        rst |=> prio_a_r == tlic_pkg::REG_RST)
        else $error("level a not cleared by reset");

    chk_flag_no_set: assert property (
        @(posedge clk_i) disable iff (rst)
        (wr_en && hit_sta && set_w == '0)
        |=> (stat_r & ~$past(stat_r)) == '0)
        else $error("status write set a flag");

    chk_word_lsb: assert property (
        @(posedge clk_i) disable iff (rst)
        word_acc_i |=> !acc_addr_o[0])
        else $error("word access kept odd address");

    chk_vec_addr_pair: assert property (
        @(posedge clk_i) disable iff (rst)
        exc_take_o |-> exc_vec_addr_o
            == 16'(exc_vector_o) << tlic_pkg::VEC_SH)
        else $error("vector address does not match number");

    chk_mask_respected: assert property (
        @(posedge clk_i) disable iff (rst)
        (take_int && !nmi_pend_r) |-> (ok0 || (ok1 && any1)))
        else $error("masked request taken");

endmodule

// ### logic/tlic_pkg.sv
package tlic_pkg;

    // ************************************************************
    // register map: printed offsets are indices, bus address is x4
    // ************************************************************
    localparam int ADDR_W = 18;
    localparam logic [15:0] SYSCTL_IDX = 16'hfff2;
    localparam logic [15:0] SENSE_IDX = 16'hfff4;
    localparam logic [15:0] ENABLE_IDX = 16'hfff5;
    localparam logic [15:0] STATUS_IDX = 16'hfff6;
    localparam logic [15:0] PRIO_A_IDX = 16'hfff8;
    localparam logic [15:0] PRIO_B_IDX = 16'hfff9;
    localparam logic [1:0] WORD_LSBS = 2'h0;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] SYSCTL_RST = 8'h0b;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int UBE_BIT = 3;
    localparam int NES_BIT = 2;

    // ************************************************************
    // sources and vector numbers
    // ************************************************************
    localparam int NUM_PINS = 6;
    localparam int NUM_INT = 30;
    localparam int NUM_SRC = NUM_PINS + NUM_INT;
    localparam int SRC_W = 6;
    localparam int CPU_AW = 24;
    localparam logic [7:0] VEC_NMI = 8'h07;
    localparam logic [7:0] VEC_TRAP = 8'h08;
    localparam logic [7:0] VEC_PIN = 8'h0c;
    localparam logic [7:0] VEC_INT = 8'h14;
    localparam int VEC_SH = 2;

    typedef enum logic {st_block, st_run} tlic_state_t;

    // priority bit of a request pin within {level_a, level_b}
    function automatic logic [3:0] pin_prio_bit(input int i);
        if (i == 0) return 4'hf;
        else if (i == 1) return 4'he;
        else if (i < 4) return 4'hd;
        else return 4'hc;
    endfunction

    // priority bit of a peripheral source: watchdog, refresh, five
    // timer channels of three, dma of four, two serial of four, adc
    function automatic logic [3:0] int_prio_bit(input int k);
        if (k < 2) return 4'hb;
        else if (k < 5) return 4'ha;
        else if (k < 8) return 4'h9;
        else if (k < 11) return 4'h8;
        else if (k < 14) return 4'h7;
        else if (k < 17) return 4'h6;
        else if (k < 21) return 4'h5;
        else if (k < 25) return 4'h3;
        else if (k < 29) return 4'h2;
        else return 4'h1;
    endfunction

endpackage

// ### verif/tlic_cpu_model.sv
`timescale 1ns/1ps

// ************************************************************
// cpu core stand-in: instruction ends, mask bits, trap requests
// ************************************************************
module tlic_cpu_model (
    input wire logic clk_i, // system clock
    input wire logic srst_i, // sync reset, active high
    input wire logic run_i, // core executing instructions
    input wire logic load_i, // load mask bits from the bench
    input wire logic ld_i_i, // mask bit to load
    input wire logic ld_um_i, // user or mask bit to load
    input wire logic trap_go_i, // start a trap instruction
    input wire logic [1:0] trap_n_i, // its vector number
    input wire logic take_i, // exception accepted
    input wire logic [7:0] vec_i, // accepted vector
    input wire logic set_i_i, // set mask bit
    input wire logic set_um_i, // set user or mask bit
    output logic imask_o, // mask bit
    output logic umask_o, // user or mask bit
    output logic boundary_o, // instruction finished
    output logic trap_o, // trap waiting
    output logic [1:0] trap_num_o // trap number
);
    logic [1:0] cnt_r;

    // one instruction per four cycles, so takes wait a few cycles
    assign boundary_o = run_i && cnt_r == 2'h3;

    // mask bits follow the set pulses; a trap is held until it is taken
    always @(posedge clk_i) begin
        if (srst_i) begin
            cnt_r <= 2'h0;
            imask_o <= 1'b1;
            umask_o <= 1'b0;
            trap_o <= 1'b0;
            trap_num_o <= 2'h0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            if (load_i) begin
                imask_o <= ld_i_i;
                umask_o <= ld_um_i;
            end
            if (set_i_i) imask_o <= 1'b1;
            if (set_um_i) umask_o <= 1'b1;
            if (trap_go_i) begin
                trap_o <= 1'b1;
                trap_num_o <= trap_n_i;
            end else if (take_i && vec_i[7:2] == 6'h02) begin
                trap_o <= 1'b0;
            end
        end
    end
endmodule

// ### verif/test_two_level_interrupt_controller.sv
`timescale 1ns/1ps

// ************************************************************
// self-checking bench for the interrupt controller
// ************************************************************
module test_two_level_interrupt_controller;
    typedef struct packed {
        logic [15:0] pr;
        logic [5:0] pin;
        logic [29:0] irq;
        logic [7:0] sys;
        logic i;
        logic um;
        logic [7:0] vec;
    } tlic_row_t;

    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hw_standby_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [tlic_pkg::ADDR_W-1:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic nmi_i = 1'b1;
    logic [5:0] irq_n_i = 6'h3f;
    logic [29:0] int_req_i = '0;
    logic word_acc_i = 1'b0;
    logic [23:0] acc_addr_i = '0;
    logic run = 1'b0, load = 1'b0, ld_i = 1'b0, ld_um = 1'b0;
    logic trap_go = 1'b0;
    logic [1:0] trap_n = 2'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, imask, umask, boundary, trap;
    logic exc_take_o, set_i_o, set_um_o, int_pend_o;
    logic [1:0] trap_num;
    logic [23:0] acc_addr_o;
    logic [7:0] exc_vector_o;
    logic [15:0] exc_vec_addr_o;
    logic [7:0] rd;
    logic er, got;
    int fails = 0, tests_run = 0, cyc = 0;
    tlic_row_t r;

    // pr = {level a, level b}; i,um; vector 00 means nothing taken
    localparam tlic_row_t ROWS [11] = '{
        {16'h0000, 6'h00, 30'h1, 8'h0b, 2'h0, 8'h14},
        {16'h0000, 6'h00, 30'h20000000, 8'h0b, 2'h0, 8'h31},
        {16'h0002, 6'h00, 30'h20000001, 8'h0b, 2'h0, 8'h31},
        {16'h0000, 6'h00, 30'h24, 8'h0b, 2'h0, 8'h16},
        {16'h8000, 6'h01, 30'h1, 8'h0b, 2'h0, 8'h0c},
        {16'h0800, 6'h02, 30'h1, 8'h0b, 2'h0, 8'h14},
        {16'h0000, 6'h00, 30'h0, 8'h0b, 2'h0, 8'h0d},
        {16'h0800, 6'h00, 30'h1, 8'h0b, 2'h2, 8'h00},
        {16'h0800, 6'h00, 30'h1, 8'h03, 2'h2, 8'h14},
        {16'h0800, 6'h00, 30'h1, 8'h03, 2'h3, 8'h00},
        {16'h0000, 6'h00, 30'h4, 8'h03, 2'h2, 8'h00}};
    localparam logic [15:0] IXS [6] = '{tlic_pkg::SYSCTL_IDX,
        tlic_pkg::SENSE_IDX, tlic_pkg::ENABLE_IDX, tlic_pkg::STATUS_IDX,
        tlic_pkg::PRIO_A_IDX, tlic_pkg::PRIO_B_IDX};
    localparam logic [7:0] RSTV [6] = '{tlic_pkg::SYSCTL_RST, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};

    tlic_top dut (.clk_i(clk_i), .srst_i(srst_i),
        .hw_standby_i(hw_standby_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .nmi_i(nmi_i), .irq_n_i(irq_n_i),
        .int_req_i(int_req_i), .imask_i(imask), .umask_i(umask),
        .boundary_i(boundary), .trap_i(trap), .trap_num_i(trap_num),
        .word_acc_i(word_acc_i), .acc_addr_i(acc_addr_i),
        .acc_addr_o(acc_addr_o), .exc_take_o(exc_take_o),
        .exc_vector_o(exc_vector_o), .exc_vec_addr_o(exc_vec_addr_o),
        .set_i_o(set_i_o), .set_um_o(set_um_o), .int_pend_o(int_pend_o));

    tlic_cpu_model cpu (.clk_i(clk_i), .srst_i(srst_i), .run_i(run),
        .load_i(load), .ld_i_i(ld_i), .ld_um_i(ld_um), .trap_go_i(trap_go),
        .trap_n_i(trap_n), .take_i(exc_take_o), .vec_i(exc_vector_o),
        .set_i_i(set_i_o), .set_um_i(set_um_o), .imask_o(imask),
        .umask_o(umask), .boundary_o(boundary), .trap_o(trap),
        .trap_num_o(trap_num));

    // clock and hang guard; a run this short never nears the ceiling
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] g,
            input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] ix,
            input logic [7:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {ix, tlic_pkg::WORD_LSBS};
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        chk("pready", pready_o, 1'b1);
        rd = prdata_o[7:0];
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // waits four instruction ends for a take, then checks its vector
    task automatic take_is(input logic [7:0] v);
        got = 1'b0;
        for (int n = 0; n < 16 && !got; n++) begin
            @(posedge clk_i);
            #1;
            got = exc_take_o === 1'b1;
        end
        chk("taken", got, v != 8'h00);
        chk("pending", int_pend_o, v != 8'h00 && v[7:2] != 6'h02);
        if (got) begin
            chk("vector", exc_vector_o, v);
            chk("vector address", exc_vec_addr_o, {v, 2'h0});
            chk("mask set", set_i_o, 1'b1);
        end
    endtask

    task automatic regs_reset();
        foreach (IXS[k]) begin
            apb(1'b0, IXS[k], 8'h00);
            chk("reset value", rd, RSTV[k]);
        end
    endtask

    // main sequence: reset, nmi cases, table rows, then traps, alignment and standby
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        regs_reset();
        apb(1'b0, 16'h0000, 8'h00);
        chk("unmapped error", er, 1'b1);
        apb(1'b1, tlic_pkg::STATUS_IDX, 8'hff);
        apb(1'b0, tlic_pkg::STATUS_IDX, 8'h00);
        chk("status after ones", rd, 8'h00);
        @(posedge clk_i);
        nmi_i <= 1'b0;
        take_is(8'h00);
        @(posedge clk_i);
        run <= 1'b1;
        take_is(tlic_pkg::VEC_NMI);
        @(posedge clk_i);
        nmi_i <= 1'b1;
        take_is(8'h00);
        apb(1'b1, tlic_pkg::SYSCTL_IDX, 8'h0f);
        nmi_i <= 1'b0;
        take_is(8'h00);
        @(posedge clk_i);
        nmi_i <= 1'b1;
        take_is(tlic_pkg::VEC_NMI);
        apb(1'b1, tlic_pkg::ENABLE_IDX, 8'h3f);
        apb(1'b1, tlic_pkg::SENSE_IDX, 8'h3f);
        foreach (ROWS[k]) begin
            r = ROWS[k];
            apb(1'b1, tlic_pkg::PRIO_A_IDX, r.pr[15:8]);
            apb(1'b1, tlic_pkg::PRIO_B_IDX, r.pr[7:0]);
            apb(1'b1, tlic_pkg::SYSCTL_IDX, r.sys);
            @(posedge clk_i);
            load <= 1'b1;
            ld_i <= r.i;
            ld_um <= r.um;
            irq_n_i <= ~r.pin;
            int_req_i <= r.irq;
            @(posedge clk_i);
            load <= 1'b0;
            take_is(r.vec);
            @(posedge clk_i);
            irq_n_i <= 6'h3f;
            int_req_i <= '0;
        end
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, tlic_pkg::SYSCTL_IDX, n[0] ? 8'h03 : 8'h0b);
            @(posedge clk_i);
            trap_go <= 1'b1;
            trap_n <= n[1:0];
            @(posedge clk_i);
            trap_go <= 1'b0;
            take_is(tlic_pkg::VEC_TRAP + 8'(n));
            chk("user bit set", set_um_o, n[0]);
        end
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            word_acc_i <= k[0];
            acc_addr_i <= 24'h000123;
            repeat (2) @(posedge clk_i);
            #1;
            chk("aligned", acc_addr_o, k[0] ? 24'h000122 : 24'h000123);
        end
        apb(1'b1, tlic_pkg::PRIO_A_IDX, 8'hff);
        apb(1'b1, tlic_pkg::SYSCTL_IDX, 8'h00);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        regs_reset();
        test_done();
    end
endmodule
